/* rtl/adc_port_map.vh */
`ifndef ADC_PORT_MAP_VH
`define ADC_PORT_MAP_VH

// Register selection codes, communications word bits [6:4]
`define SEL_COMM        3'h0
`define SEL_MODE        3'h1
`define SEL_FILT_HI     3'h2
`define SEL_FILT_LO     3'h3
`define SEL_DATA        3'h5
`define SEL_ZERO_CAL    3'h6
`define SEL_FULL_CAL    3'h7

// Communications word fields
`define COMM_DATA_READY_N_BIT   7
`define COMM_SEL_HI     6
`define COMM_SEL_LO     4
`define COMM_READ_BIT   3

// Filter high byte: set selects unipolar coding
`define FILT_UNIPOLAR_BIT 7

// Register widths in bits
`define W_BYTE          5'h08
`define W_WORD          5'h18

// Reset values
`define COMM_RST        8'h00
`define MODE_RST        8'h00
`define FILT_HI_RST     8'h01
`define FILT_LO_RST     8'h40
`define ZERO_CAL_RST    24'h800000
`define FULL_CAL_RST    24'h5761AB

// Ready-high window before an update over an unread result, master clocks
`define DATA_READY_N_HOLD_CYC   10'h1F4

// Synchroniser bit positions
`define SY_CS           0
`define SY_SCK          1
`define SY_DIN          2
`define SY_POL          3
`define SY_SYNC         4
`define SY_RST          5
`define SY_N            6

`endif

/* rtl/adc_serial_port.v */
// Function
// - Serial transfers count only while chip_select_n is low.
// - Chip select tied low gives a three-wire port on clock, in, out.
// - data_ready_n goes low when a new result sits in the data register.
// - data_ready_n returns high after a full data word is read.
// - Unread result: ready high 500 clocks before update, then low again.
// - data_ready_n also goes low when calibration completes.
// - serial_out shifts out a register chosen by the selection bits.
// - serial_in fills a register chosen by selection bits; data never written.
// - Bipolar output is offset binary, midscale between 0111.. and 1000..
// - Polarity low: first clock edge rises; high: first edge falls.
// - Filter sync resets filter and calibration paths, not interface or low ready.
// - Reset pin low returns all logic but the input synchroniser to power-on state.
`include "adc_port_map.vh"

module adc_serial_port #(
   parameter HOLD_CYC = `DATA_READY_N_HOLD_CYC
) (
   input  wire        sys_clk_i,
   input  wire        sys_rst_i,
   input  wire        chip_select_n_i,
   input  wire        serial_clock_i,
   input  wire        serial_in_i,
   input  wire        clock_polarity_sel_i,
   input  wire        filter_sync_n_i,
   input  wire        reset_n_i,
   input  wire        result_valid_i,
   input  wire [23:0] result_i,
   input  wire        cal_done_i,
   output reg         serial_out_o,
   output reg         data_ready_n_o,
   output reg  [7:0]  mode_o,
   output reg  [15:0] filter_sel_o,
   output reg  [23:0] zero_cal_o,
   output reg  [23:0] full_cal_o,
   output reg         filter_reset_o
);

   localparam ST_COMM = 2'b01;
   localparam ST_REG  = 2'b10;

   function [4:0] sel_width;
      input [2:0] sel;
      begin
         case (sel)
            `SEL_DATA, `SEL_ZERO_CAL, `SEL_FULL_CAL: sel_width = `W_WORD;
            default:                                 sel_width = `W_BYTE;
         endcase
      end
   endfunction

   reg  [`SY_N-1:0] sy1_ff;
   reg  [`SY_N-1:0] sy2_ff;
   reg  [`SY_N-1:0] sy3_ff;
   reg  [`SY_N-1:0] filt_ff;
   reg              sck_d_ff;
   reg  [1:0]       state_ff;
   reg  [7:0]       comm_ff;
   reg  [23:0]      data_ff;
   reg  [23:0]      stage_ff;
   reg  [23:0]      in_sh_ff;
   reg  [23:0]      out_sh_ff;
   reg  [4:0]       cnt_ff;
   reg  [9:0]       hold_ff;
   reg              holding_ff;

   // Input agrees on stages two and three before it counts
   wire [`SY_N-1:0] nxt_filt = (~(sy2_ff ^ sy3_ff) & sy2_ff) | ((sy2_ff ^ sy3_ff) & filt_ff);

   wire       rst      = sys_rst_i | ~filt_ff[`SY_RST];
   wire       cs_act   = ~filt_ff[`SY_CS];
   wire       clock_polarity_sel      = filt_ff[`SY_POL];
   wire       lead     = cs_act & (sck_d_ff == clock_polarity_sel) & (filt_ff[`SY_SCK] != clock_polarity_sel);
   wire       sync_act = ~filt_ff[`SY_SYNC];
   wire [2:0] sel      = comm_ff[`COMM_SEL_HI:`COMM_SEL_LO];
   wire       rd       = comm_ff[`COMM_READ_BIT];
   wire [4:0] width    = (state_ff == ST_COMM) ? `W_BYTE : sel_width(sel);
   wire       last     = lead & (cnt_ff == width - 5'h01);
   wire [23:0] word_in = {in_sh_ff[22:0], filt_ff[`SY_DIN]};
   wire [23:0] coded   = filter_sel_o[8 + `FILT_UNIPOLAR_BIT] ? result_i :
                         {~result_i[23], result_i[22:0]};
   wire [7:0] comm_rd  = {data_ready_n_o, word_in[6:0]};
   reg  [23:0] rd_val;

   always @*
   begin
      // Select comes from the incoming byte, comm_ff loads on the same edge
      case (word_in[`COMM_SEL_HI:`COMM_SEL_LO])
         `SEL_COMM:     rd_val = {comm_rd, 16'h0000};
         `SEL_MODE:     rd_val = {mode_o, 16'h0000};
         `SEL_FILT_HI:  rd_val = {filter_sel_o[15:8], 16'h0000};
         `SEL_FILT_LO:  rd_val = {filter_sel_o[7:0], 16'h0000};
         `SEL_DATA:     rd_val = data_ff;
         `SEL_ZERO_CAL: rd_val = zero_cal_o;
         `SEL_FULL_CAL: rd_val = full_cal_o;
         default:       rd_val = 24'h000000;
      endcase
   end

   // Synchroniser runs from the system reset only, so the pin reset is seen
   always @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         sy1_ff   <= {`SY_N{1'b1}};
         sy2_ff   <= {`SY_N{1'b1}};
         sy3_ff   <= {`SY_N{1'b1}};
         filt_ff  <= {`SY_N{1'b1}};
         sck_d_ff <= 1'b1;
      end
      else
      begin
         sy1_ff   <= {reset_n_i, filter_sync_n_i, clock_polarity_sel_i,
                      serial_in_i, serial_clock_i, chip_select_n_i};
         sy2_ff   <= sy1_ff;
         sy3_ff   <= sy2_ff;
         filt_ff  <= nxt_filt;
         sck_d_ff <= filt_ff[`SY_SCK];
      end
   end

   // Serial engine, samples and shifts on the leading clock edge
   always @(posedge sys_clk_i)
   begin
      if (rst)
      begin
         state_ff     <= ST_COMM;
         comm_ff      <= `COMM_RST;
         mode_o       <= `MODE_RST;
         filter_sel_o <= {`FILT_HI_RST, `FILT_LO_RST};
         zero_cal_o   <= `ZERO_CAL_RST;
         full_cal_o   <= `FULL_CAL_RST;
         in_sh_ff     <= 24'h000000;
         out_sh_ff    <= 24'h000000;
         cnt_ff       <= 5'h00;
         serial_out_o <= 1'b1;
      end
      else
      begin
         serial_out_o <= out_sh_ff[23];
         if (!cs_act)
            cnt_ff <= 5'h00;
         else if (lead)
         begin
            in_sh_ff  <= word_in;
            out_sh_ff <= {out_sh_ff[22:0], 1'b1};
            cnt_ff    <= cnt_ff + 5'h01;
            if (last)
            begin
               cnt_ff <= 5'h00;
               case (state_ff)
                  ST_COMM:
                  begin
                     comm_ff  <= word_in[7:0];
                     state_ff <= ST_REG;
                     if (word_in[`COMM_READ_BIT])
                        out_sh_ff <= rd_val;
                  end
                  ST_REG:
                  begin
                     state_ff  <= ST_COMM;
                     out_sh_ff <= 24'hFFFFFF;
                     if (!rd)
                     begin
                        case (sel)
                           `SEL_COMM:     comm_ff <= word_in[7:0];
                           `SEL_MODE:     mode_o <= word_in[7:0];
                           `SEL_FILT_HI:  filter_sel_o[15:8] <= word_in[7:0];
                           `SEL_FILT_LO:  filter_sel_o[7:0] <= word_in[7:0];
                           `SEL_ZERO_CAL: zero_cal_o <= word_in;
                           `SEL_FULL_CAL: full_cal_o <= word_in;
                           default:       comm_ff <= comm_ff;
                        endcase
                        if (sel == `SEL_COMM)
                           state_ff <= ST_REG;
                     end
                  end
                  default: state_ff <= ST_COMM;
               endcase
            end
         end
      end
   end

   wire data_read_done = last & (state_ff == ST_REG) & rd & (sel == `SEL_DATA);

   // Ready flag and data register; a read finishing sends a new result of the same cycle into the hold
   always @(posedge sys_clk_i)
   begin
      if (rst)
      begin
         data_ready_n_o <= 1'b1;
         data_ff        <= 24'h000000;
         stage_ff       <= 24'h000000;
         hold_ff        <= 10'h000;
         holding_ff     <= 1'b0;
         filter_reset_o <= 1'b1;
      end
      else
      begin
         filter_reset_o <= sync_act;
         if (data_read_done)
            data_ready_n_o <= 1'b1;
         if (sync_act)
            holding_ff <= 1'b0;
         else if (holding_ff)
         begin
            hold_ff <= hold_ff - 10'h001;
            if (hold_ff == 10'h001)
            begin
               holding_ff     <= 1'b0;
               data_ff        <= stage_ff;
               data_ready_n_o <= 1'b0;
            end
         end
         else if (result_valid_i)
         begin
            if (data_ready_n_o && !data_read_done)
            begin
               data_ff        <= coded;
               data_ready_n_o <= 1'b0;
            end
            else
            begin
               // Unread result: flag goes high so host avoids a torn read
               stage_ff       <= coded;
               hold_ff        <= HOLD_CYC[9:0];
               holding_ff     <= 1'b1;
               data_ready_n_o <= 1'b1;
            end
         end
         else if (cal_done_i)
            data_ready_n_o <= 1'b0;
      end
   end

endmodule // adc_serial_port

/* tb/port_checker.sv */
`include "adc_port_map.vh"
module port_checker #(
   parameter HOLD_CYC = `DATA_READY_N_HOLD_CYC
) (
   input wire        sys_clk_i,
   input wire        sys_rst_i,
   input wire        chip_select_n_i,
   input wire        filter_sync_n_i,
   input wire        reset_n_i,
   input wire        result_valid_i,
   input wire        cal_done_i,
   input wire        data_ready_n_o,
   input wire [7:0]  mode_o,
   input wire [23:0] zero_cal_o,
   input wire        filter_reset_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge sys_clk_i);
   endclocking
   default disable iff (sys_rst_i);
   // Saturating count of ready-high cycles tells a long idle from a hold
   logic [10:0] hi_cnt;
   logic        hold_ff;
   always @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         hi_cnt  <= 11'h000;
         hold_ff <= 1'b0;
      end
      else
      begin
         hi_cnt  <= !data_ready_n_o ? 11'h000 : hi_cnt + {10'h000, hi_cnt != 11'h7FF};
         hold_ff <= (result_valid_i && !data_ready_n_o && !filter_reset_o)
                    || (hold_ff && data_ready_n_o && !filter_reset_o && reset_n_i);
      end
   end
   AST_RDY_LOW: assert property (result_valid_i && !filter_reset_o && hi_cnt > HOLD_CYC + 1
      |=> !data_ready_n_o) else $error("ready not low after result");
   AST_HOLD_LEN: assert property ($fell(data_ready_n_o) && hold_ff |-> hi_cnt == HOLD_CYC)
      else $error("ready high window has wrong length");
   AST_CAL: assert property (cal_done_i && !result_valid_i && !filter_reset_o
      && hi_cnt > HOLD_CYC + 1 |=> !data_ready_n_o) else $error("ready not low after cal");
   AST_SYNC_KEEP: assert property (filter_reset_o && !data_ready_n_o && chip_select_n_i
      && $past(chip_select_n_i, 6) && reset_n_i |=> !data_ready_n_o)
      else $error("filter sync cleared ready");
   AST_FRST_ON: assert property (!filter_sync_n_i [*8] |-> filter_reset_o)
      else $error("filter reset not raised");
   AST_FRST_OFF: assert property ((filter_sync_n_i && reset_n_i) [*8] |-> !filter_reset_o)
      else $error("filter reset stuck high");
   AST_CS_IDLE: assert property (chip_select_n_i && $past(chip_select_n_i, 6) && reset_n_i
      && $past(reset_n_i, 6) |-> $stable(mode_o) && $stable(zero_cal_o))
      else $error("register changed while deselected");
   AST_PORST: assert property (!reset_n_i [*6] |-> data_ready_n_o && mode_o == `MODE_RST
      && zero_cal_o == `ZERO_CAL_RST) else $error("pin reset incomplete");
endmodule // port_checker

/* tb/host_model.sv */
module host_model (
   input  wire  sys_clk_i,
   input  wire  pol_i,
   input  wire  dout_i,
   output logic cs_n_o,
   output logic sclk_o,
   output logic din_o
);
   timeunit 1ns;
   timeprecision 1ns;
   initial cs_n_o = 1'b1;
   initial sclk_o = 1'b0;
   initial din_o = 1'b0;
   task automatic half();
      repeat (4) @(posedge sys_clk_i);
      #1;
   endtask
   // Clock stands at idle level between units; released data toggles
   task automatic xfer(input logic cs, input logic cs_end, input int n,
                       input logic [31:0] tx, output logic [31:0] rx);
      rx = 32'h0;
      sclk_o = pol_i;
      half();
      cs_n_o = cs;
      for (int i = n - 1; i >= 0; i--)
      begin
         din_o = tx[i];
         half();
         rx[i] = dout_i;
         sclk_o = ~pol_i;
         half();
         sclk_o = pol_i;
      end
      half();
      cs_n_o = cs_end;
      din_o = ~din_o;
   endtask
endmodule // host_model

/* tb/tb_top.sv */
`include "adc_port_map.vh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int HC = 5;
   logic        sys_clk_i = 1'b0;
   logic        sys_rst_i = 1'b1;
   logic        clock_polarity_sel_i = 1'b0;
   logic        filter_sync_n_i = 1'b1;
   logic        reset_n_i = 1'b1;
   logic        result_valid_i = 1'b0;
   logic        cal_done_i = 1'b0;
   logic [23:0] result_i = 24'h000000;
   logic [31:0] rx;
   logic [23:0] regs [8];
   logic [2:0]  sels [5] = '{`SEL_MODE, `SEL_FILT_HI, `SEL_FILT_LO, `SEL_ZERO_CAL, `SEL_FULL_CAL};
   int          fail_count = 0;
   int          n_checks = 0;
   wire         chip_select_n_i, serial_clock_i, serial_in_i, serial_out_o;
   wire         data_ready_n_o, filter_reset_o;
   wire [7:0]   mode_o;
   wire [15:0]  filter_sel_o;
   wire [23:0]  zero_cal_o, full_cal_o;
   adc_serial_port #(.HOLD_CYC(HC)) i_dut (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i),
      .chip_select_n_i(chip_select_n_i),
      .serial_clock_i(serial_clock_i),
      .serial_in_i(serial_in_i),
      .clock_polarity_sel_i(clock_polarity_sel_i),
      .filter_sync_n_i(filter_sync_n_i),
      .reset_n_i(reset_n_i),
      .result_valid_i(result_valid_i),
      .result_i(result_i),
      .cal_done_i(cal_done_i),
      .serial_out_o(serial_out_o),
      .data_ready_n_o(data_ready_n_o),
      .mode_o(mode_o),
      .filter_sel_o(filter_sel_o),
      .zero_cal_o(zero_cal_o),
      .full_cal_o(full_cal_o),
      .filter_reset_o(filter_reset_o)
   );
   host_model i_host (
      .sys_clk_i(sys_clk_i),
      .pol_i(clock_polarity_sel_i),
      .dout_i(serial_out_o),
      .cs_n_o(chip_select_n_i),
      .sclk_o(serial_clock_i),
      .din_o(serial_in_i)
   );
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic results();
      $display("checks=%0d mismatches=%0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic pulse_result();
      result_i = $urandom;
      @(posedge sys_clk_i) #1 result_valid_i = 1'b1;
      @(posedge sys_clk_i) #1 result_valid_i = 1'b0;
   endtask
   // Select kept low across both units: three-wire use
   task automatic read_data(input logic [23:0] r);
      i_host.xfer(1'b0, 1'b0, 8, {24'h0, 1'b0, `SEL_DATA, 4'h8}, rx);
      i_host.xfer(1'b0, 1'b1, 24, 32'h0, rx);
      check(rx, {8'h00, regs[2][7] ? r : {~r[23], r[22:0]}});
   endtask
   initial
      forever #25 sys_clk_i = ~sys_clk_i;
   initial
   begin
      #1_000_000;
      fail_count++;
      results();
   end
   initial
   begin
      logic [31:0] v;
      int          w;
      void'($urandom(32'h5B4E));
      regs[1] = `MODE_RST;
      regs[2] = `FILT_HI_RST;
      regs[3] = `FILT_LO_RST;
      regs[6] = `ZERO_CAL_RST;
      regs[7] = `FULL_CAL_RST;
      repeat (4) @(posedge sys_clk_i);
      #1 sys_rst_i = 1'b0;
      repeat (8) @(posedge sys_clk_i);
      #1 check({data_ready_n_o, full_cal_o}, {8'h01, regs[7]});
      check({zero_cal_o, mode_o}, {regs[6], regs[1][7:0]});
      // Comm read shows the idle ready flag in its top bit
      i_host.xfer(1'b0, 1'b1, 8, {24'h0, 1'b0, `SEL_COMM, 4'h8}, rx);
      i_host.xfer(1'b0, 1'b1, 8, 32'h0, rx);
      check(rx, {24'h0, 1'b1, `SEL_COMM, 4'h8});
      foreach (sels[k])
      begin
         w = sels[k] > 3'h5 ? 24 : 8;
         v = $urandom & ((32'h1 << w) - 1);
         regs[sels[k]] = v[23:0];
         clock_polarity_sel_i = k[0];
         @(posedge sys_clk_i) #1;
         i_host.xfer(1'b0, 1'b1, 8, {24'h0, 1'b0, sels[k], 4'h0}, rx);
         i_host.xfer(1'b0, 1'b1, w, v, rx);
         i_host.xfer(1'b0, 1'b1, 8, {24'h0, 1'b0, sels[k], 4'h8}, rx);
         i_host.xfer(1'b0, 1'b1, w, 32'h0, rx);
         check(rx, v);
      end
      check(filter_sel_o, {regs[2][7:0], regs[3][7:0]});
      check({zero_cal_o, mode_o}, {regs[6], regs[1][7:0]});
      check(full_cal_o, regs[7]);
      i_host.xfer(1'b1, 1'b1, 8, {24'h0, 1'b0, `SEL_MODE, 4'h0}, rx);
      i_host.xfer(1'b1, 1'b1, 8, ~v, rx);
      check(mode_o, regs[1]);
      pulse_result();
      check(data_ready_n_o, 1'b0);
      read_data(result_i);
      repeat (4) @(posedge sys_clk_i);
      #1 check(data_ready_n_o, 1'b1);
      pulse_result();
      pulse_result();
      check(data_ready_n_o, 1'b1);
      repeat (HC - 1) @(posedge sys_clk_i);
      #1 check(data_ready_n_o, 1'b1);
      @(posedge sys_clk_i);
      #1 check(data_ready_n_o, 1'b0);
      read_data(result_i);
      repeat (10) @(posedge sys_clk_i);
      #1 cal_done_i = 1'b1;
      @(posedge sys_clk_i) #1 cal_done_i = 1'b0;
      check(data_ready_n_o, 1'b0);
      filter_sync_n_i = 1'b0;
      repeat (8) @(posedge sys_clk_i);
      #1 check({filter_reset_o, data_ready_n_o}, 2'b10);
      filter_sync_n_i = 1'b1;
      repeat (8) @(posedge sys_clk_i);
      #1 check({filter_reset_o, data_ready_n_o}, 2'b00);
      reset_n_i = 1'b0;
      repeat (8) @(posedge sys_clk_i);
      #1 check({data_ready_n_o, zero_cal_o}, {8'h01, regs[6] & 24'h0 | `ZERO_CAL_RST});
      results();
   end
endmodule // tb_top
bind adc_serial_port port_checker #(.HOLD_CYC(HOLD_CYC)) i_chk (
   .sys_clk_i(sys_clk_i),
   .sys_rst_i(sys_rst_i),
   .chip_select_n_i(chip_select_n_i),
   .filter_sync_n_i(filter_sync_n_i),
   .reset_n_i(reset_n_i),
   .result_valid_i(result_valid_i),
   .cal_done_i(cal_done_i),
   .data_ready_n_o(data_ready_n_o),
   .mode_o(mode_o),
   .zero_cal_o(zero_cal_o),
   .filter_reset_o(filter_reset_o)
);
